// *** verilog/vpic_top.sv ***
// vectored priority interrupt controller with ahb-lite register port
// assumes sources synchronous to hclk and a core taking active-low requests
// Function
// - source zero feeds the fast request line
// - source one is the combined system interrupt
// - other sources are peripherals or external inputs
// - internal sources choose edge or level sensing
// - external sources choose edge, level, polarity
// - eight priority levels decide normal request
// - higher priority pending nests over serviced one
// - per-source enable mask blocks any request
// - one writable 32-bit vector per source
// - vector read returns currently signalled source vector
// - protect mode stops read side effects
// - any source can be forced onto fast line
// - general mask blocks both lines, pending visible
// - fixed source numbering of peripherals and externals
// - numbering matches power manager clock enable bits
//
// Added by the designer: the address map and the AHB-Lite slave port.
`timescale 1ns/100ps
module vpic_top
	import vpic_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic fast_interrupt_input,
	input wire logic system_interrupt_source,
	input wire logic [13:0] periph_irq,
	input wire logic external_interrupt_zero,
	input wire logic external_interrupt_one,
	output logic normal_interrupt_request_n,
	output logic fast_interrupt_request_n,
	output logic evt_irq
);
	import vpic_pkg::*;

	typedef struct packed {
		logic [NSRC-1:0][SMR_W-1:0] smr;
		logic [NSRC-1:0][31:0] svr;
		logic [31:0] imr;
		logic [31:0] ffsr;
		logic [31:0] edge_pend;
		logic [31:0] prev_adj;
		logic [31:0] spu;
		logic protect;
		logic gmask;
		logic [1:0] evs;
		logic [1:0] evm;
		logic [1:0] req_prev;
		logic [STK_N-1:0][SMR_PRI_W-1:0] stk_pri;
		logic [STK_N-1:0][4:0] stk_src;
		logic [3:0] depth;
		logic [31:0] hrdata;
		logic normal_interrupt_request_n_n;
		logic fast_interrupt_request_n_n;
		logic evt_irq;
	} vpic_state_t;

	vpic_state_t s;
	vpic_state_t next_s;

	logic wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic rd_en;
	logic [ADDR_W-1:0] rd_addr;
	logic [31:0] raw;
	logic [31:0] adj;
	logic [31:0] edge_sel;
	logic [31:0] pend;
	logic [31:0] fsel;
	logic [31:0] cand;
	logic fiq_cond;
	logic found;
	logic [4:0] best_src;
	logic [SMR_PRI_W-1:0] best_pri;
	logic [2:0] top_idx;
	logic [SMR_PRI_W-1:0] top_pri;
	logic [4:0] top_src;
	logic irq_cond;
	logic [31:0] ivr_vec;
	logic [31:0] fvr_vec;
	logic ack_seen;

	function automatic logic [SMR_PRI_W-1:0] pri_of(input logic [NSRC-1:0][SMR_W-1:0] m,
			input logic [4:0] i);
		return m[i][SMR_PRI_W-1:0];
	endfunction

	// polarity applies to external sources only
	function automatic logic [31:0] cond_level(input logic [31:0] r,
			input logic [NSRC-1:0][SMR_W-1:0] m);
		logic [31:0] o;
		o = '0;
		for (int i = 0; i < NSRC; i++) begin
			o[i] = (SRC_EXT[i] && !m[i][SMR_POL]) ? !r[i] : r[i];
		end
		return o;
	endfunction

	function automatic logic [31:0] edge_bits(input logic [NSRC-1:0][SMR_W-1:0] m);
		logic [31:0] o;
		o = '0;
		for (int i = 0; i < NSRC; i++) begin
			o[i] = m[i][SMR_EDGE];
		end
		return o;
	endfunction

	// highest priority wins, lowest number on a tie
	function automatic logic [5:0] best_find(input logic [31:0] c,
			input logic [NSRC-1:0][SMR_W-1:0] m);
		logic f;
		logic [4:0] b;
		f = 1'b0;
		b = '0;
		for (int i = 0; i < NSRC; i++) begin
			if (c[i] && (!f || pri_of(m, 5'(i)) > pri_of(m, b))) begin
				f = 1'b1;
				b = 5'(i);
			end
		end
		return {f, b};
	endfunction

	vpic_ahb_slave vpic_ahb_slave_i (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.rd_en(rd_en),
		.rd_addr(rd_addr)
	);

	// source vector in fixed numbering
	assign raw = {external_interrupt_one, external_interrupt_zero, 14'h0000, periph_irq,
		system_interrupt_source, fast_interrupt_input};
	assign adj = cond_level(raw, s.smr);
	assign edge_sel = edge_bits(s.smr);
	assign pend = SRC_VALID & ((edge_sel & s.edge_pend) | (~edge_sel & adj));
	assign fsel = s.ffsr | FAST_FIXED;
	assign cand = pend & s.imr & ~fsel;
	assign fiq_cond = |(pend & s.imr & fsel);
	assign {found, best_src} = best_find(cand, s.smr);
	assign best_pri = pri_of(s.smr, best_src);
	assign top_idx = 3'(s.depth - 4'h1);
	assign top_pri = (s.depth == 4'h0) ? '0 : s.stk_pri[top_idx];
	assign top_src = (s.depth == 4'h0) ? '0 : s.stk_src[top_idx];
	assign irq_cond = found && (s.depth == 4'h0 || best_pri > top_pri);
	assign ivr_vec = irq_cond ? s.svr[best_src] : s.spu;
	assign fvr_vec = fiq_cond ? s.svr[SRC_FAST] : s.spu;
	// acknowledge by vector read, or by vector write in protect mode
	assign ack_seen = (rd_en && rd_addr == OFS_IVR && !s.protect)
		|| (wr_en && wr_addr == OFS_IVR && s.protect);

	always_comb begin
		logic [31:0] d;
		logic [31:0] clr;
		logic [31:0] setm;
		logic [31:0] rdv;
		logic [1:0] evset;
		logic [1:0] evclr;
		next_s = s;
		d = hwdata;
		clr = '0;
		setm = '0;
		rdv = '0;
		evclr = '0;
		evset = '0;
		// register reads
		if (rd_en) begin
			if (rd_addr < OFS_SVR0) begin
				rdv = {27'h0, s.smr[rd_addr[6:2]]};
			end else if (rd_addr < OFS_IVR) begin
				rdv = s.svr[rd_addr[6:2]];
			end else begin
				unique case (rd_addr)
					OFS_IVR: rdv = ivr_vec;
					OFS_FVR: rdv = fvr_vec;
					OFS_ISR: rdv = {27'h0, top_src};
					OFS_IPR: rdv = pend;
					OFS_IMR: rdv = s.imr;
					OFS_DCR: rdv = {30'h0, s.gmask, s.protect};
					OFS_FFSR: rdv = s.ffsr;
					OFS_EVS: rdv = {30'h0, s.evs};
					OFS_EVM: rdv = {30'h0, s.evm};
					OFS_SPU: rdv = s.spu;
					default: rdv = '0;
				endcase
			end
			if (rd_addr == OFS_FVR && !s.protect) begin
				clr[SRC_FAST] = 1'b1;
			end
			if (rd_addr == OFS_EVS && !s.protect) begin
				evclr = 2'h3;
			end
		end
		next_s.hrdata = rdv;
		// register writes
		if (wr_en) begin
			if (wr_addr < OFS_SVR0) begin
				next_s.smr[wr_addr[6:2]] = d[SMR_W-1:0];
			end else if (wr_addr < OFS_IVR) begin
				next_s.svr[wr_addr[6:2]] = d;
			end else begin
				unique case (wr_addr)
					OFS_IECR: next_s.imr = s.imr | (d & SRC_VALID);
					OFS_IDCR: next_s.imr = s.imr & ~d;
					OFS_ICCR: clr = clr | d;
					OFS_ISCR: setm = d & SRC_VALID;
					OFS_DCR: begin
						next_s.protect = d[DCR_PROT];
						next_s.gmask = d[DCR_GMSK];
					end
					OFS_FFER: next_s.ffsr = s.ffsr | (d & SRC_VALID & ~FAST_FIXED);
					OFS_FFDR: next_s.ffsr = s.ffsr & ~d;
					OFS_EVM: next_s.evm = d[1:0];
					OFS_SPU: next_s.spu = d;
					default: ;
				endcase
			end
		end
		// acknowledge enters the source into service
		if (ack_seen && irq_cond) begin
			clr[best_src] = 1'b1;
			next_s.stk_pri[s.depth[2:0]] = best_pri;
			next_s.stk_src[s.depth[2:0]] = best_src;
			next_s.depth = s.depth + 4'h1;
		end else if (wr_en && wr_addr == OFS_EOICR && s.depth != 4'h0) begin
			next_s.depth = s.depth - 4'h1;
		end
		// edge capture; a new edge beats a clear
		next_s.prev_adj = adj;
		next_s.edge_pend = (s.edge_pend & ~clr) | setm | (adj & ~s.prev_adj);
		// event status, set beats read clear
		evset = {fiq_cond, irq_cond} & ~s.req_prev;
		next_s.req_prev = {fiq_cond, irq_cond};
		next_s.evs = (s.evs & ~evclr) | evset;
		next_s.evt_irq = |(next_s.evs & s.evm);
		// request lines, general mask blocks both
		next_s.fast_interrupt_request_n_n = !(fiq_cond && !s.gmask);
		next_s.normal_interrupt_request_n_n = !(irq_cond && !s.gmask);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.spu <= SPU_RST;
			// idle level of low-active sources, no false edge after reset
			s.prev_adj <= SRC_EXT;
			s.normal_interrupt_request_n_n <= 1'b1;
			s.fast_interrupt_request_n_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign hrdata = s.hrdata;
	assign normal_interrupt_request_n = s.normal_interrupt_request_n_n;
	assign fast_interrupt_request_n = s.fast_interrupt_request_n_n;
	assign evt_irq = s.evt_irq;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	chk_fast_line: assert property (fiq_cond && !s.gmask |=> !fast_interrupt_request_n)
		else $error("fast request not asserted");
	chk_gmask_blocks: assert property (s.gmask
		|=> normal_interrupt_request_n && fast_interrupt_request_n)
		else $error("request asserted under general mask");
	chk_masked_quiet: assert property ((pend & s.imr) == 32'h0
		|=> normal_interrupt_request_n && fast_interrupt_request_n)
		else $error("request from masked sources");
	chk_unused_src: assert property (((s.imr | s.ffsr) & ~SRC_VALID) == 32'h0)
		else $error("unused source enabled");
	chk_nest_higher: assert property (irq_cond && s.depth != 4'h0 && !s.gmask
		|-> best_pri > top_pri ##1 !normal_interrupt_request_n)
		else $error("nesting not honoured");
	chk_ack_push: assert property (ack_seen && irq_cond
		|=> s.depth == $past(s.depth) + 4'h1 && !(s.depth == 4'h0))
		else $error("acknowledge did not enter service");
	chk_vector_read: assert property (rd_en && rd_addr == OFS_IVR && irq_cond
		|=> hrdata == $past(ivr_vec))
		else $error("wrong current vector");
	chk_protect_keep: assert property (rd_en && rd_addr == OFS_IVR && s.protect
		&& !(wr_en && (wr_addr == OFS_EOICR || wr_addr == OFS_IVR))
		|=> $stable(s.depth))
		else $error("read changed state in protect mode");
	chk_edge_catch: assert property (s.smr[SRC_EXT1][SMR_EDGE] && adj[SRC_EXT1]
		&& !s.prev_adj[SRC_EXT1] |=> s.edge_pend[SRC_EXT1])
		else $error("edge lost");
	chk_eoi_pop: assert property (wr_en && wr_addr == OFS_EOICR && s.depth != 4'h0
		&& !(ack_seen && irq_cond) |=> s.depth == $past(s.depth) - 4'h1)
		else $error("end of interrupt did not pop");
	chk_event_set: assert property (irq_cond && !s.req_prev[EV_IRQ] |=> s.evs[EV_IRQ])
		else $error("normal request event lost");
	chk_vector_write: assert property (wr_en && wr_addr >= OFS_SVR0 && wr_addr < OFS_IVR
		|=> s.svr[$past(wr_addr[6:2])] == $past(hwdata))
		else $error("vector write lost");
	chk_fast_vector: assert property (rd_en && rd_addr == OFS_FVR && fiq_cond
		|=> hrdata == $past(s.svr[SRC_FAST]))
		else $error("wrong fast vector");
	chk_force_line: assert property ((pend & s.imr & s.ffsr) != 32'h0 && !s.gmask
		|=> !fast_interrupt_request_n)
		else $error("forced source not on fast line");
endmodule

// *** verilog/vpic_pkg.sv ***
// shared constants of the vectored priority interrupt controller
// assumes a 32-bit AHB-Lite slave port with 12 decoded address bits
package vpic_pkg;
	localparam int NSRC = 32;
	localparam int ADDR_W = 12;
	localparam int STK_N = 8;
	// source numbering, shared with the power manager clock enables
	localparam int SRC_FAST = 0;
	localparam int SRC_SYS = 1;
	localparam int SRC_IO_A = 2;
	localparam int SRC_SPI = 5;
	localparam int SRC_SER0 = 6;
	localparam int SRC_TWI = 9;
	localparam int SRC_PWM = 10;
	localparam int SRC_LCD = 11;
	localparam int SRC_TMR0 = 12;
	localparam int SRC_ADC = 15;
	localparam int SRC_EXT0 = 30;
	localparam int SRC_EXT1 = 31;
	localparam logic [31:0] SRC_VALID = 32'hC000FEFF;
	localparam logic [31:0] SRC_EXT = 32'hC0000001;
	localparam logic [31:0] FAST_FIXED = 32'h00000001;
	// mode word layout
	localparam int SMR_W = 5;
	localparam int SMR_PRI_W = 3;
	localparam int SMR_EDGE = 3;
	localparam int SMR_POL = 4;
	// register offsets
	localparam logic [11:0] OFS_SMR0 = 12'h000;
	localparam logic [11:0] OFS_SVR0 = 12'h080;
	localparam logic [11:0] OFS_IVR = 12'h100;
	localparam logic [11:0] OFS_FVR = 12'h104;
	localparam logic [11:0] OFS_ISR = 12'h108;
	localparam logic [11:0] OFS_IPR = 12'h10C;
	localparam logic [11:0] OFS_IMR = 12'h110;
	localparam logic [11:0] OFS_IECR = 12'h114;
	localparam logic [11:0] OFS_IDCR = 12'h118;
	localparam logic [11:0] OFS_ICCR = 12'h11C;
	localparam logic [11:0] OFS_ISCR = 12'h120;
	localparam logic [11:0] OFS_EOICR = 12'h124;
	localparam logic [11:0] OFS_DCR = 12'h128;
	localparam logic [11:0] OFS_FFER = 12'h12C;
	localparam logic [11:0] OFS_FFDR = 12'h130;
	localparam logic [11:0] OFS_FFSR = 12'h134;
	localparam logic [11:0] OFS_EVS = 12'h138;
	localparam logic [11:0] OFS_EVM = 12'h13C;
	localparam logic [11:0] OFS_SPU = 12'h140;
	localparam int DCR_PROT = 0;
	localparam int DCR_GMSK = 1;
	localparam int EV_IRQ = 0;
	localparam int EV_FIQ = 1;
	localparam logic [31:0] SPU_RST = 32'h00000000;
	// bus encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// *** verilog/vpic_ahb_slave.sv ***
// ahb-lite slave front end: turns bus transfers into register strobes
// assumes a single master, word transfers, the one slave's hreadyout is hready
`timescale 1ns/100ps
module vpic_ahb_slave
	import vpic_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic wr_en,
	output logic [vpic_pkg::ADDR_W-1:0] wr_addr,
	output logic rd_en,
	output logic [vpic_pkg::ADDR_W-1:0] rd_addr
);
	import vpic_pkg::*;

	typedef struct packed {
		logic wr_pend;
		logic [ADDR_W-1:0] wr_addr;
		logic hreadyout;
		logic hresp;
	} vpic_slv_t;

	vpic_slv_t s;
	vpic_slv_t next_s;
	logic take;

	// a transfer is accepted on any active htrans with the bus ready
	assign take = hsel && htrans[1] && hready;
	assign rd_en = take && !hwrite;
	assign rd_addr = haddr[ADDR_W-1:0];
	assign wr_en = s.wr_pend;
	assign wr_addr = s.wr_addr;
	assign hreadyout = s.hreadyout;
	assign hresp = s.hresp;

	always_comb begin
		next_s = s;
		next_s.hreadyout = 1'b1;
		next_s.hresp = 1'b0;
		// non-word writes are dropped, still answered okay
		next_s.wr_pend = take && hwrite && (hsize == HSIZE_WORD);
		if (take) begin
			next_s.wr_addr = haddr[ADDR_W-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.hreadyout <= 1'b1;
		end else begin
			s <= next_s;
		end
	end
endmodule

// *** bench/vpic_core_model.sv ***
// core-side model: counts requests taken on the two active-low lines
// assumes request lines registered on hclk and held high in reset
`timescale 1ns/100ps
module vpic_core_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic irq_n,
	input wire logic fiq_n,
	output logic [7:0] irq_cnt,
	output logic [7:0] fiq_cnt
);
	logic irq_q;
	logic fiq_q;
	// a request is taken on each falling edge of a line
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_q <= 1'b1;
			fiq_q <= 1'b1;
			irq_cnt <= 8'h00;
			fiq_cnt <= 8'h00;
		end else begin
			irq_q <= irq_n;
			fiq_q <= fiq_n;
			if (irq_q && !irq_n) begin
				irq_cnt <= irq_cnt + 8'h01;
			end
			if (fiq_q && !fiq_n) begin
				fiq_cnt <= fiq_cnt + 8'h01;
			end
		end
	end
endmodule

// *** bench/vpic_tb_top.sv ***
// self-checking bench of the interrupt controller with a core model
// assumes hready fed back from hreadyout, one bus master
`timescale 1ns/100ps
module vpic_tb_top;
	import vpic_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic fiq_in, sys_in, ext0, ext1, irq_n, fiq_n, evt_irq;
	logic [13:0] periph_irq;
	logic [7:0] irq_cnt, fiq_cnt, base;
	int err_total, samples_checked;
	assign hready = hreadyout;
	always #12.5 hclk = ~hclk;
	vpic_top vpic_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fast_interrupt_input(fiq_in),
		.system_interrupt_source(sys_in), .periph_irq(periph_irq),
		.external_interrupt_zero(ext0), .external_interrupt_one(ext1),
		.normal_interrupt_request_n(irq_n), .fast_interrupt_request_n(fiq_n), .evt_irq(evt_irq));
	vpic_core_model vpic_core_model_i (.hclk(hclk), .hresetn(hresetn), .irq_n(irq_n),
		.fiq_n(fiq_n), .irq_cnt(irq_cnt), .fiq_cnt(fiq_cnt));
	task end_sim;
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task hang;
		err_total++;
		$display("[ERR] %0t wait bound used up", $time);
		end_sim;
	endtask
	task automatic edge_rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 40);
		if (hready !== 1'b1) hang;
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {20'h00000, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		hsize <= HSIZE_WORD;
		edge_rdy;
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		edge_rdy;
		q = hrdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
		logic [31:0] q;
		bus(1'b0, a, 32'h00000000, q);
		cmp(q, exp, what);
		cmp({31'h0, hresp}, 32'h0, "response");
	endtask
	// wait a settle time, then up to 8 cycles for the expected line levels
	task automatic lines(input int pre, input logic en, input logic ef, input string what);
		int n;
		n = 0;
		repeat (pre) @(posedge hclk);
		while ((irq_n !== en || fiq_n !== ef) && n < 8) begin
			@(posedge hclk);
			n++;
		end
		cmp({30'h0, irq_n, fiq_n}, {30'h0, en, ef}, what);
		if (irq_n !== en || fiq_n !== ef) hang;
	endtask
	task set_src(input int n, input logic v);
		case (n)
			0: fiq_in <= v;
			1: sys_in <= v;
			30: ext0 <= v;
			31: ext1 <= v;
			default: periph_irq[n-2] <= v;
		endcase
	endtask
	function automatic logic [31:0] vec(input int n);
		return 32'hC0DE0000 | 32'(n);
	endfunction
	task cfg(input int n, input logic [31:0] mode);
		wr(OFS_SMR0 + 12'(n * 4), mode);
		wr(OFS_SVR0 + 12'(n * 4), vec(n));
		wr(OFS_ICCR, 32'h1 << n);
		wr(OFS_IECR, 32'h1 << n);
	endtask
	task t_reset;
		lines(0, 1'b1, 1'b1, "reset lines");
		rdc(OFS_IMR, 32'h00000000, "reset mask");
		rdc(OFS_SPU, SPU_RST, "reset spurious");
		rdc(12'h200, 32'h00000000, "unmapped");
		set_src(30, 1'b1);
		wr(OFS_SMR0 + 12'h078, 32'h13);
		lines(4, 1'b1, 1'b1, "masked source");
		rdc(OFS_IPR, 32'hC0000001, "masked pending");
		set_src(30, 1'b0);
	endtask
	task t_ids;
		for (int n = 1; n < 32; n++) begin
			if (n == 8 || (n > 15 && n < 30)) continue;
			cfg(n, 32'h13);
			set_src(n, 1'b1);
			lines(0, 1'b0, 1'b1, "numbered source");
			rdc(OFS_IVR, vec(n), "vector");
			rdc(OFS_ISR, 32'(n), "in service");
			lines(0, 1'b1, 1'b1, "after ack");
			set_src(n, 1'b0);
			wr(OFS_EOICR, 32'h0);
			wr(OFS_IDCR, 32'h1 << n);
		end
	endtask
	task t_nest;
		base = irq_cnt;
		cfg(5, 32'h02);
		cfg(12, 32'h0E);
		set_src(5, 1'b1);
		lines(0, 1'b0, 1'b1, "low pri");
		rdc(OFS_IVR, vec(5), "low vector");
		lines(2, 1'b1, 1'b1, "same pri held");
		set_src(12, 1'b1);
		@(posedge hclk);
		set_src(12, 1'b0);
		lines(0, 1'b0, 1'b1, "nested");
		rdc(OFS_IVR, vec(12), "nested vector");
		rdc(OFS_ISR, 32'd12, "nested service");
		wr(OFS_EOICR, 32'h0);
		rdc(OFS_ISR, 32'd5, "popped");
		set_src(5, 1'b0);
		wr(OFS_EOICR, 32'h0);
		cmp(32'(irq_cnt), 32'(base) + 32'd2, "irq taken");
		wr(OFS_IDCR, 32'h1020);
	endtask
	task t_ext;
		rdc(OFS_EVS, 32'h1, "event sticky");
		rdc(OFS_EVS, 32'h0, "event cleared");
		set_src(31, 1'b1);
		cfg(31, 32'h0D);
		wr(OFS_EVM, 32'h1);
		lines(4, 1'b1, 1'b1, "rise ignored");
		set_src(31, 1'b0);
		lines(0, 1'b0, 1'b1, "falling edge");
		wr(OFS_DCR, 32'h1);
		rdc(OFS_IVR, vec(31), "protect vector");
		lines(2, 1'b0, 1'b1, "protect no ack");
		rdc(OFS_EVS, 32'h1, "protect event");
		cmp({31'h0, evt_irq}, 32'h1, "event irq");
		wr(OFS_EVM, 32'h0);
		repeat (2) @(posedge hclk);
		cmp({31'h0, evt_irq}, 32'h0, "event masked");
		wr(OFS_IVR, 32'h0);
		lines(0, 1'b1, 1'b1, "protect ack");
		wr(OFS_DCR, 32'h0);
		rdc(OFS_EVS, 32'h1, "event read");
		rdc(OFS_EVS, 32'h0, "event clear");
		wr(OFS_EOICR, 32'h0);
		wr(OFS_IDCR, 32'h80000000);
	endtask
	task t_fast;
		base = fiq_cnt;
		wr(OFS_SVR0, vec(0));
		wr(OFS_SMR0, 32'h10);
		wr(OFS_IECR, 32'h1);
		set_src(0, 1'b1);
		lines(0, 1'b1, 1'b0, "fast source");
		rdc(OFS_FVR, vec(0), "fast vector");
		set_src(0, 1'b0);
		lines(0, 1'b1, 1'b1, "fast idle");
		wr(OFS_FFER, 32'h200);
		cfg(9, 32'h07);
		set_src(9, 1'b1);
		lines(4, 1'b1, 1'b0, "forced");
		rdc(OFS_FFSR, 32'h00000200, "force status");
		wr(OFS_DCR, 32'h2);
		lines(4, 1'b1, 1'b1, "general mask");
		rdc(OFS_IPR, 32'h200, "pending seen");
		wr(OFS_DCR, 32'h0);
		lines(0, 1'b1, 1'b0, "unmasked");
		repeat (2) @(posedge hclk);
		cmp(32'(fiq_cnt), 32'(base) + 32'd3, "fiq taken");
		set_src(9, 1'b0);
		wr(OFS_FFDR, 32'h200);
		wr(OFS_IDCR, 32'h201);
		set_src(8, 1'b1);
		wr(OFS_SMR0 + 12'h020, 32'h17);
		wr(OFS_IECR, 32'h100);
		lines(4, 1'b1, 1'b1, "unused quiet");
		rdc(OFS_IPR, 32'h0, "unused pending");
		set_src(8, 1'b0);
		wr(OFS_SPU, 32'h00005A50);
		rdc(OFS_IVR, 32'h00005A50, "spurious vector");
	endtask
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		{hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
		{fiq_in, sys_in, ext0, ext1, periph_irq} = '0;
		err_total = 0;
		samples_checked = 0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset;
		t_ids;
		t_nest;
		t_ext;
		t_fast;
		end_sim;
	end
endmodule
